// File: hw/arxf_rx.sv
// Asynchronous receiver: start detect, bit voting, address filter, buffer
`timescale 1ns/100ps
module arxf_rx
	import arxf_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       serial_rx_line,
	input  wire logic       sample_tick,
	input  wire logic       rx_enable,
	input  wire logic       double_speed_select,
	input  wire logic       addr_filter_enable,
	input  wire logic [2:0] char_size_code,
	input  wire logic       parity_enable,
	input  wire logic       parity_odd,
	input  wire logic       data_read,
	output logic [7:0]      serial_data_reg,
	output logic            rx_ninth_bit,
	output logic            rx_complete_flag,
	output logic            frame_error_flag,
	output logic            parity_error_flag,
	output logic            overrun_flag
);
	typedef enum {ARXF_IDLE, ARXF_START, ARXF_BITS} arxf_state_t;

	logic        rx_meta;
	logic        rx_sync;
	logic        rx_prev;
	arxf_state_t state;
	arxf_state_t next_state;
	logic [4:0]  sample;
	logic [4:0]  next_sample;
	logic [3:0]  bit_idx;
	logic [3:0]  next_bit_idx;
	logic [2:0]  votes;
	logic [2:0]  next_votes;
	logic [10:0] shift;
	logic [10:0] next_shift;
	logic        pend_ovr;
	logic        next_pend_ovr;
	logic        push;
	arxf_word_t  push_word;
	logic        fifo_ready;
	arxf_word_t  head;
	logic        head_valid;
	logic [4:0]  spb;
	logic [4:0]  vote_first;
	logic [3:0]  data_bits;
	logic [3:0]  frame_bits;
	logic        voted;
	logic        frame_type;
	logic [8:0]  data_masked;
	logic        par_calc;
	logic        pop;

	// ==================================================
	// Two-stage synchroniser for the receive line
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end
		else
		begin
			rx_meta <= serial_rx_line;
			rx_sync <= rx_meta;
		end
	end

	// ==================================================
	// Frame timing and voting
	always_comb
	begin
		spb        = double_speed_select ? ARXF_SPB_DOUBLE : ARXF_SPB_NORMAL;
		vote_first = double_speed_select ? ARXF_VOTE_D : ARXF_VOTE_N;
		data_bits  = (char_size_code == ARXF_SIZE_9BIT) ? 4'h9
			: ARXF_MIN_BITS + {1'b0, char_size_code};
		frame_bits = data_bits + {3'h0, parity_enable} + 4'h1;
		voted      = (votes[0] & votes[1]) | (votes[0] & votes[2])
			| (votes[1] & votes[2]);
		next_state    = state;
		next_sample   = sample;
		next_bit_idx  = bit_idx;
		next_votes    = votes;
		next_shift    = shift;
		push          = 1'b0;
		if (sample_tick)
		begin
			case (state)
				ARXF_IDLE:
				begin
					// Sample 1 is the first low sample after a high one
					if (rx_prev && !rx_sync)
					begin
						next_state  = ARXF_START;
						next_sample = 5'h02;
						next_votes  = '0;
					end
				end
				ARXF_START, ARXF_BITS:
				begin
					if (sample >= vote_first && sample <= vote_first + 5'h02)
						next_votes = {votes[1:0], rx_sync};
					next_sample = sample + 5'h01;
					if (state == ARXF_START && sample == vote_first + 5'h02)
					begin
						// At most one high sample keeps the start bit
						if (((votes[0] & votes[1]) | (votes[0] & rx_sync)
							| (votes[1] & rx_sync)))
							next_state = ARXF_IDLE;
					end
					else if (state == ARXF_BITS && sample == vote_first + 5'h03)
					begin
						next_shift   = {voted, shift[10:1]};
						next_bit_idx = bit_idx + 4'h1;
						if (bit_idx == frame_bits - 4'h1)
						begin
							push       = 1'b1;
							next_state = ARXF_IDLE;
							// A low right after the stop votes is already sample 1
							if (rx_prev && !rx_sync)
							begin
								next_state  = ARXF_START;
								next_sample = 5'h02;
								next_votes  = '0;
							end
						end
					end
					if (next_sample > spb)
					begin
						next_sample = 5'h01;
						if (state == ARXF_START)
						begin
							next_state   = ARXF_BITS;
							next_bit_idx = '0;
						end
					end
				end
				default: next_state = ARXF_IDLE;
			endcase
		end
		if (!rx_enable)
			next_state = ARXF_IDLE;
	end

	// ==================================================
	// Frame assembly and address filter
	always_comb
	begin
		// Align so bit 0 of the frame is at index 0
		logic [10:0] aligned;
		aligned     = 11'h000;
		aligned     = next_shift >> (4'hb - frame_bits);
		data_masked = aligned[8:0] & ~(9'h1ff << data_bits);
		par_calc    = ^data_masked ^ parity_odd;
		frame_type  = (char_size_code == ARXF_SIZE_9BIT)
			? aligned[8] : aligned[frame_bits - 4'h1];
		push_word.data             = data_masked;
		push_word.frame_error_flag = ~aligned[frame_bits - 4'h1];
		push_word.parity_error     = parity_enable
			&& (par_calc != aligned[data_bits]);
		push_word.overrun          = pend_ovr;
		// Filter drops data frames; address frames pass as normal
		// Filter gates only this receive buffer, never a transmit path
		next_pend_ovr = pend_ovr;
		if (push && !(addr_filter_enable && !frame_type))
		begin
			if (fifo_ready)
				next_pend_ovr = 1'b0;
			else
				next_pend_ovr = 1'b1; // Lost frame noted for next store
		end
		if (!rx_enable)
			next_pend_ovr = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state    <= ARXF_IDLE;
			sample   <= '0;
			bit_idx  <= '0;
			votes    <= '0;
			shift    <= '0;
			pend_ovr <= 1'b0;
			rx_prev  <= 1'b1;
		end
		else
		begin
			state    <= next_state;
			sample   <= next_sample;
			bit_idx  <= next_bit_idx;
			votes    <= next_votes;
			shift    <= next_shift;
			pend_ovr <= next_pend_ovr;
			rx_prev  <= sample_tick ? rx_sync : rx_prev;
		end
	end

	// ==================================================
	// Receive buffer; frame and parity errors travel with their frame, overrun with the next stored one
	arxf_fifo #(
		.W (ARXF_WORD_W),
		.D (ARXF_FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.flush     (!rx_enable),
		.in_data   (push_word),
		.in_valid  (push && !(addr_filter_enable && !frame_type)),
		.in_ready  (fifo_ready),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (pop)
	);

	assign pop = data_read && head_valid && rx_enable;

	// Registered view of the buffer head
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			serial_data_reg   <= 8'h00;
			rx_ninth_bit      <= 1'b0;
			rx_complete_flag  <= 1'b0;
			frame_error_flag  <= 1'b0;
			parity_error_flag <= 1'b0;
			overrun_flag      <= 1'b0;
		end
		else
		begin
			serial_data_reg   <= head_valid ? head.data[7:0] : 8'h00;
			rx_ninth_bit      <= head_valid & head.data[8];
			rx_complete_flag  <= head_valid;
			frame_error_flag  <= head_valid & head.frame_error_flag;
			parity_error_flag <= head_valid & head.parity_error;
			overrun_flag      <= head_valid & head.overrun;
		end
	end

	// ==================================================
	// Checks
	property p_reject_start;
		@(posedge core_clk) disable iff (!reset_n)
		(state == ARXF_START) |-> ##[0:300] (state != ARXF_START);
	endproperty
	a_reject_start: assert property (p_reject_start)
		else $error("start phase did not end");

	property p_sample_range;
		@(posedge core_clk) disable iff (!reset_n)
		(state != ARXF_IDLE) |-> (sample >= 5'h01 && sample <= spb);
	endproperty
	a_sample_range: assert property (p_sample_range)
		else $error("sample state out of range");

	property p_filter_drop;
		@(posedge core_clk) disable iff (!reset_n)
		(push && addr_filter_enable && !frame_type && !head_valid)
			|=> !head_valid;
	endproperty
	a_filter_drop: assert property (p_filter_drop)
		else $error("filtered frame reached buffer");

	property p_flag_follow;
		@(posedge core_clk) disable iff (!reset_n)
		(push && rx_enable && addr_filter_enable && frame_type && fifo_ready)
			|=> ##1 rx_complete_flag;
	endproperty
	a_flag_follow: assert property (p_flag_follow)
		else $error("complete flag missing");

	// Decision tick of the first stop bit
	sequence s_stop_vote;
		sample_tick && rx_enable && state == ARXF_BITS
			&& sample == vote_first + 5'h03 && bit_idx == frame_bits - 4'h1;
	endsequence

	property p_stop_error;
		@(posedge core_clk) disable iff (!reset_n)
		s_stop_vote |-> (push_word.frame_error_flag == !voted);
	endproperty
	a_stop_error: assert property (p_stop_error)
		else $error("frame error does not follow stop vote");

	property p_early_start;
		@(posedge core_clk) disable iff (!reset_n)
		s_stop_vote ##0 (rx_prev && !rx_sync)
			|=> (state == ARXF_START && sample == 5'h02);
	endproperty
	a_early_start: assert property (p_early_start)
		else $error("start right after stop vote missed");
endmodule : arxf_rx

// File: include/arxf_pkg.sv
// Package for the asynchronous receive back end with address filter
package arxf_pkg;
	// ==================================================
	// Sampling and voting
	localparam logic [4:0] ARXF_SPB_NORMAL = 5'h10;  // Samples per bit, normal speed
	localparam logic [4:0] ARXF_SPB_DOUBLE = 5'h08;  // Samples per bit, double speed
	localparam logic [4:0] ARXF_VOTE_N     = 5'h08;  // First vote sample, normal
	localparam logic [4:0] ARXF_VOTE_D     = 5'h04;  // First vote sample, double
	localparam logic [4:0] ARXF_MID_N      = 5'h09;  // Middle vote sample, normal
	localparam logic [4:0] ARXF_MID_D      = 5'h05;  // Middle vote sample, double
	// ==================================================
	// Frame format and receive buffer
	localparam logic [2:0] ARXF_SIZE_9BIT  = 3'h7;   // Nine-bit character code
	localparam logic [3:0] ARXF_MIN_BITS   = 4'h5;   // Data bits at size code 0
	localparam int         ARXF_FIFO_DEPTH = 16;     // Receive buffer depth
	localparam int         ARXF_WORD_W     = 12;     // Stored word width

	// Word kept in the receive buffer
	typedef struct packed {
		logic       frame_error_flag;
		logic       parity_error;
		logic [8:0] data;
		logic       overrun;
	} arxf_word_t;
endpackage : arxf_pkg

// File: hw/arxf_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module arxf_fifo #(
	parameter int W = 12,
	parameter int D = 16
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic         flush,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0]   next_count;
	logic          push;
	logic          pop;

	// ==================================================
	// Pointer and count update
	always_comb
	begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		if (flush)
		begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage array
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	assign in_ready  = (count != D[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
endmodule : arxf_fifo

// File: dv/arxf_tx_model.sv
// Behavioural remote transmitter driving the receive line
`timescale 1ns/100ps
module arxf_tx_model (
	input  wire logic core_clk,
	input  wire logic sample_tick,
	output logic      serial_rx_line
);
	// ==================================================
	// Line driver, idle high
	initial serial_rx_line = 1'b1;

	// Bit time is locked to the sample ticks, so the rate error is zero
	task automatic tick_wait;
		int i;
		for (i = 0; i < 16; i++)
		begin
			@(posedge core_clk);
			if (sample_tick === 1'b1)
				break;
		end
		if (i == 16)
			tb.n_mismatch++;
	endtask : tick_wait

	// Sends n bits LSB first, spb samples each; bit fb gets sample flips fm,
	// bit cut lasts clen samples; the line returns high afterwards
	task automatic send(input logic [31:0] v, input int n, input int spb, input int fb,
		input logic [15:0] fm, input int cut, input int clen);
		int b, s;
		tick_wait();
		for (b = 0; b < n; b++)
			for (s = 0; s < ((b == cut) ? clen : spb); s++)
			begin
				serial_rx_line <= v[b] ^ ((b == fb) ? fm[s] : 1'b0);
				tick_wait();
			end
		serial_rx_line <= 1'b1;
	endtask : send
endmodule : arxf_tx_model

// File: dv/tb.sv
// Self-checking testbench for the receiver with address filter
`timescale 1ns/100ps
module tb;
	import arxf_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0, sample_tick = 1'b0, ds = 1'b0, af = 1'b0;
	logic pen = 1'b0, podd = 1'b0, data_read = 1'b0, serial_rx_line, nine, rxc, fe, pe, ov;
	logic [2:0] csz = 3'h3;
	logic [2:0] tcnt = 3'h0;
	logic [7:0] rdat;
	int n_mismatch = 0;
	int compares = 0;

	// ==================================================
	// Clock, a sample tick every eight clocks, design and far end
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		tcnt <= tcnt + 3'h1;
		sample_tick <= (tcnt == 3'h7);
	end
	arxf_rx dut_u (.core_clk(core_clk), .reset_n(reset_n), .serial_rx_line(serial_rx_line),
		.sample_tick(sample_tick), .rx_enable(1'b1), .double_speed_select(ds),
		.addr_filter_enable(af), .char_size_code(csz), .parity_enable(pen),
		.parity_odd(podd), .data_read(data_read), .serial_data_reg(rdat),
		.rx_ninth_bit(nine), .rx_complete_flag(rxc), .frame_error_flag(fe),
		.parity_error_flag(pe), .overrun_flag(ov));
	arxf_tx_model tx_u (.core_clk(core_clk), .sample_tick(sample_tick),
		.serial_rx_line(serial_rx_line));

	// ==================================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// Builds a frame in the current format; two repeats it, first stop cut after its votes
	task automatic frame(input logic [8:0] d, input logic stp, input logic pbad,
		input logic two, input int fb, input logic [15:0] fm);
		logic [31:0] v;
		logic p;
		int nd, k, spb;
		nd = (csz == ARXF_SIZE_9BIT) ? 9 : int'(csz) + int'(ARXF_MIN_BITS);
		spb = ds ? int'(ARXF_SPB_DOUBLE) : int'(ARXF_SPB_NORMAL);
		v = '0;
		p = podd;
		for (k = 0; k < nd; k++)
		begin
			v[k+1] = d[k];
			p = p ^ d[k];
		end
		v[nd+1] = pen ? p ^ pbad : stp;
		if (pen)
			v[nd+2] = stp;
		k = nd + 2 + int'(pen);
		if (two)
			v = v | (v << k);
		tx_u.send(v, two ? 2 * k : k, spb, fb, fm, two ? k - 1 : -1, spb / 2 + 2);
	endtask : frame

	// Waits for a stored word, compares it with its flags, then pops it
	task automatic take(input logic [8:0] d, input logic efe, input logic epe, input logic eov);
		int w;
		for (w = 0; w < 4000 && rxc !== 1'b1; w++)
			cyc(1);
		if (w == 4000)
		begin
			n_mismatch++;
			close_out();
		end
		cyc(1);
		chk("data", {nine, rdat}, d);
		chk("frame error", fe, efe);
		chk("parity error", pe, epe);
		chk("overrun", ov, eov);
		data_read <= 1'b1;
		cyc(1);
		data_read <= 1'b0;
		cyc(3);
	endtask : take

	// Long quiet wait, then nothing may be stored
	task automatic none;
		cyc(200);
		chk("complete", rxc, 1'b0);
	endtask : none

	// ==================================================
	// Scenarios
	// Two flipped samples in bit d3 move the vote only inside the window
	task automatic s_vote;
		logic [15:0] m [4] = '{16'h00c0, 16'h0180, 16'h0300, 16'h0600};
		for (int s = 0; s < 2; s++)
			for (int i = 0; i < 4; i++)
			begin
				ds <= s[0];
				cyc(1);
				frame(9'h05a, 1'b1, 1'b0, 1'b0, 4, m[i] >> (4 * s));
				take((i == 1 || i == 2) ? 9'h052 : 9'h05a, 1'b0, 1'b0, 1'b0);
			end
		ds <= 1'b0;
		cyc(1);
		frame(9'h0a5, 1'b1, 1'b0, 1'b0, 3, 16'h0902);
		take(9'h0a5, 1'b0, 1'b0, 1'b0);
	endtask : s_vote

	// Low stop marks its own frame; back-to-back frames start right after the stop vote
	task automatic s_ferr;
		frame(9'h03c, 1'b0, 1'b0, 1'b0, -1, 16'h0);
		frame(9'h0c3, 1'b1, 1'b0, 1'b1, -1, 16'h0);
		take(9'h03c, 1'b1, 1'b0, 1'b0);
		take(9'h0c3, 1'b0, 1'b0, 1'b0);
		take(9'h0c3, 1'b0, 1'b0, 1'b0);
	endtask : s_ferr

	// Start candidates with three or two high votes are dropped, one high vote is kept
	task automatic s_spike;
		tx_u.send(32'h0, 1, 16, 0, 16'hfff8, -1, 0);
		tx_u.send(32'h0, 1, 16, 0, 16'h0180, -1, 0);
		none();
		frame(9'h077, 1'b1, 1'b0, 1'b0, 0, 16'h0100);
		take(9'h077, 1'b0, 1'b0, 1'b0);
	endtask : s_spike

	// Nine-bit frames at double speed with parity, early start included
	task automatic s_nine;
		ds <= 1'b1;
		csz <= ARXF_SIZE_9BIT;
		pen <= 1'b1;
		cyc(1);
		frame(9'h1b3, 1'b1, 1'b0, 1'b1, -1, 16'h0);
		take(9'h1b3, 1'b0, 1'b0, 1'b0);
		take(9'h1b3, 1'b0, 1'b0, 1'b0);
		podd <= 1'b1;
		cyc(1);
		frame(9'h0e1, 1'b1, 1'b1, 1'b0, -1, 16'h0);
		take(9'h0e1, 1'b0, 1'b1, 1'b0);
		pen <= 1'b0;
		podd <= 1'b0;
	endtask : s_nine

	// Filter mode keeps only frames whose type bit is one
	task automatic s_filter;
		af <= 1'b1;
		cyc(1);
		frame(9'h012, 1'b1, 1'b0, 1'b0, -1, 16'h0);
		none();
		frame(9'h1a4, 1'b1, 1'b0, 1'b0, -1, 16'h0);
		take(9'h1a4, 1'b0, 1'b0, 1'b0);
		csz <= 3'h3;
		cyc(1);
		frame(9'h055, 1'b0, 1'b0, 1'b0, -1, 16'h0);
		none();
		frame(9'h066, 1'b1, 1'b0, 1'b0, -1, 16'h0);
		take(9'h066, 1'b0, 1'b0, 1'b0);
		af <= 1'b0;
	endtask : s_filter

	// Sixteen words fill the buffer, the next is lost, the one after reports it
	task automatic s_fill;
		csz <= 3'h0;
		cyc(1);
		for (int i = 0; i < 17; i++)
			frame(9'(i), 1'b1, 1'b0, 1'b0, -1, 16'h0);
		take(9'h000, 1'b0, 1'b0, 1'b0);
		frame(9'h01e, 1'b1, 1'b0, 1'b0, -1, 16'h0);
		for (int i = 1; i < 16; i++)
			take(9'(i), 1'b0, 1'b0, 1'b0);
		take(9'h01e, 1'b0, 1'b0, 1'b1);
		none();
	endtask : s_fill

	// Main sequence
	initial
	begin
		cyc(4);
		reset_n <= 1'b1;
		cyc(2);
		s_vote();
		s_ferr();
		s_spike();
		s_nine();
		s_filter();
		s_fill();
		close_out();
	end
endmodule : tb
